// File: verilog/iiar_map.svh
/*
 * Register offsets, field positions and reset values of the
 * identification and bus-address register bank.
 * Assumes 16-bit register pointers as sent by the two-wire host.
 */
`ifndef IIAR_MAP_SVH
`define IIAR_MAP_SVH

`define IIAR_OFF_REV_HI 16'h0002
`define IIAR_OFF_ID_MID 16'h0003
`define IIAR_OFF_ID_LO_VAR_HI 16'h0004
`define IIAR_OFF_VAR_LO 16'h0005
`define IIAR_OFF_TARGET_ADDR 16'h0006
`define IIAR_OFF_SERIAL_RSVD 16'h0007

`define IIAR_REV_RST 4'h0
`define IIAR_VAR_RST 11'h000
`define IIAR_ADDR_UP_RST 5'h1F
`define IIAR_PIN_RST 2'h0
`define IIAR_SYNC_RST 4'hC

`define IIAR_POS_SCL 3
`define IIAR_POS_SDA 2
`define IIAR_POS_PIN1 1
`define IIAR_POS_PIN0 0

`define IIAR_VAR_LO_FIXED 1'b1

`endif

// File: verilog/iiar_pkg.sv
/*
 * Types shared by the identification register bank.
 * Assumes nothing of its surroundings.
 */
package iiar_pkg;
    typedef enum logic [2:0] {
        IIAR_IDLE,
        IIAR_RX,
        IIAR_ACK,
        IIAR_TX,
        IIAR_RACK
    } iiar_state_t;
endpackage : iiar_pkg

// File: verilog/iiar_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous inputs.
 * Assumes each bit is independent; no bus coherence is given.
 */
`timescale 1ns/1ps
`default_nettype none
module iiar_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : iiar_sync
`default_nettype wire

// File: verilog/iiar_regs.sv
/*
 * Identification and two-wire target-address register bank with its
 * own two-wire target interface (7-bit address, 16-bit pointer).
 * Assumes scl and sda are oversampled by a much faster clock and
 * factory configuration inputs are stable when reset is released.
 */
// What this block does
// - Revision, part identifier and variant code packed across bytes 2 to 5.
// - Variant code and upper address load from factory inputs at power-up.
// - Address byte: bit 7 zero, upper address bits 6:2, pin bits 1:0.
// - Address bits 1:0 read-only, reset zero, mirror the select pins.
// - Generic parts come up with target address 1111100b.
`timescale 1ns/1ps
`default_nettype none
`include "iiar_map.svh"
module iiar_regs import iiar_pkg::*; #(
    // Arbitrary value, stands in for the real part identifier
    parameter logic [15:0] PART_ID_DEFAULT = 16'h5A3C
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_0,
    input wire logic [10:0] factory_variant_code,
    input wire logic [4:0] factory_target_address_bits,
    output logic [6:0] target_address
);
    logic [3:0] sync_w;
    logic scl_s;
    logic sda_s;
    logic [1:0] pins_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    iiar_sync #(
        .WIDTH(4),
        .RST_VAL(`IIAR_SYNC_RST)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({scl_in, sda_in, addr_select_pin_1, addr_select_pin_0}),
        .sync_out(sync_w)
    );

    assign scl_s = sync_w[`IIAR_POS_SCL];
    assign sda_s = sync_w[`IIAR_POS_SDA];
    assign pins_s = {sync_w[`IIAR_POS_PIN1], sync_w[`IIAR_POS_PIN0]};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // Register bank state
    logic [3:0] rev_q, rev_d;
    logic [15:0] id_q, id_d;
    logic [10:0] var_q, var_d;
    logic [4:0] upper_q, upper_d;
    logic loaded_q, loaded_d;

    // Bus engine state
    iiar_state_t state_q, state_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic first_q, first_d;
    logic is_read_q, is_read_d;
    logic [1:0] byte_idx_q, byte_idx_d;
    logic [15:0] ptr_q, ptr_d;
    logic drive_low_q, drive_low_d;
    logic nack_q, nack_d;

    logic [7:0] rd_byte;
    logic [7:0] addr_byte;

    assign target_address = {upper_q, pins_s};
    assign addr_byte = {1'b0, upper_q, pins_s};

    // Read view of the pointer
    always_comb begin
        case (ptr_q)
            `IIAR_OFF_REV_HI: rd_byte = {rev_q, id_q[15:12]};
            `IIAR_OFF_ID_MID: rd_byte = id_q[11:4];
            `IIAR_OFF_ID_LO_VAR_HI: rd_byte = {id_q[3:0], var_q[10:7]};
            `IIAR_OFF_VAR_LO: rd_byte = {var_q[6:0], `IIAR_VAR_LO_FIXED};
            `IIAR_OFF_TARGET_ADDR: rd_byte = addr_byte;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        rev_d = rev_q;
        id_d = id_q;
        var_d = var_q;
        upper_d = upper_q;
        loaded_d = 1'b1;
        state_d = state_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        first_d = first_q;
        is_read_d = is_read_q;
        byte_idx_d = byte_idx_q;
        ptr_d = ptr_q;
        drive_low_d = drive_low_q;
        nack_d = nack_q;

        // Factory values taken once after reset release
        if (!loaded_q) begin
            var_d = factory_variant_code;
            upper_d = factory_target_address_bits;
        end

        case (state_q)
            IIAR_IDLE: begin
                drive_low_d = 1'b0;
            end
            IIAR_RX: begin
                if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 4'h1;
                end else if (scl_fall && cnt_q == 4'h8) begin
                    if (first_q) begin
                        if (sh_q[7:1] == {upper_q, pins_s}) begin
                            is_read_d = sh_q[0];
                            first_d = 1'b0;
                            state_d = IIAR_ACK;
                            drive_low_d = 1'b1;
                        end else begin
                            state_d = IIAR_IDLE;
                        end
                    end else begin
                        state_d = IIAR_ACK;
                        drive_low_d = 1'b1;
                        case (byte_idx_q)
                            2'd0: ptr_d = {sh_q, ptr_q[7:0]};
                            2'd1: ptr_d = {ptr_q[15:8], sh_q};
                            default: begin
                                ptr_d = ptr_q + 16'h0001;
                                case (ptr_q)
                                    `IIAR_OFF_REV_HI: begin
                                        rev_d = sh_q[7:4];
                                        id_d[15:12] = sh_q[3:0];
                                    end
                                    `IIAR_OFF_ID_MID: id_d[11:4] = sh_q;
                                    `IIAR_OFF_ID_LO_VAR_HI: begin
                                        id_d[3:0] = sh_q[7:4];
                                        var_d[10:7] = sh_q[3:0];
                                    end
                                    `IIAR_OFF_VAR_LO: var_d[6:0] = sh_q[7:1];
                                    `IIAR_OFF_TARGET_ADDR: upper_d = sh_q[6:2];
                                    default: ;
                                endcase
                            end
                        endcase
                        if (byte_idx_q != 2'd2) begin
                            byte_idx_d = byte_idx_q + 2'd1;
                        end
                    end
                end
            end
            IIAR_ACK: begin
                if (scl_fall) begin
                    cnt_d = 4'h0;
                    if (is_read_q) begin
                        sh_d = rd_byte;
                        ptr_d = ptr_q + 16'h0001;
                        drive_low_d = !rd_byte[7];
                        state_d = IIAR_TX;
                    end else begin
                        drive_low_d = 1'b0;
                        state_d = IIAR_RX;
                    end
                end
            end
            IIAR_TX: begin
                if (scl_fall) begin
                    if (cnt_q == 4'h7) begin
                        drive_low_d = 1'b0;
                        state_d = IIAR_RACK;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                        sh_d = {sh_q[6:0], 1'b0};
                        drive_low_d = !sh_q[6];
                    end
                end
            end
            IIAR_RACK: begin
                if (scl_rise) begin
                    nack_d = sda_s;
                end else if (scl_fall) begin
                    if (!nack_q) begin
                        cnt_d = 4'h0;
                        sh_d = rd_byte;
                        ptr_d = ptr_q + 16'h0001;
                        drive_low_d = !rd_byte[7];
                        state_d = IIAR_TX;
                    end else begin
                        state_d = IIAR_IDLE;
                    end
                end
            end
            default: begin
                state_d = IIAR_IDLE;
                drive_low_d = 1'b0;
            end
        endcase

        // Start and stop override any phase
        if (stop_det) begin
            state_d = IIAR_IDLE;
            drive_low_d = 1'b0;
        end else if (start_det) begin
            state_d = IIAR_RX;
            cnt_d = 4'h0;
            first_d = 1'b1;
            byte_idx_d = 2'd0;
            drive_low_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rev_q <= `IIAR_REV_RST;
            id_q <= PART_ID_DEFAULT;
            var_q <= `IIAR_VAR_RST;
            upper_q <= `IIAR_ADDR_UP_RST;
            loaded_q <= 1'b0;
            state_q <= IIAR_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            is_read_q <= 1'b0;
            byte_idx_q <= 2'd0;
            ptr_q <= 16'h0000;
            drive_low_q <= 1'b0;
            nack_q <= 1'b1;
        end else begin
            rev_q <= rev_d;
            id_q <= id_d;
            var_q <= var_d;
            upper_q <= upper_d;
            loaded_q <= loaded_d;
            state_q <= state_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            first_q <= first_d;
            is_read_q <= is_read_d;
            byte_idx_q <= byte_idx_d;
            ptr_q <= ptr_d;
            drive_low_q <= drive_low_d;
            nack_q <= nack_d;
        end
    end

    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = !drive_low_q;
endmodule : iiar_regs
`default_nettype wire

// File: verification/iiar_chk.sv
/* Port checker for iiar_regs.
   Assumes binding to every iiar_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module iiar_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_0,
    input wire logic [10:0] factory_variant_code,
    input wire logic [4:0] factory_target_address_bits,
    input wire logic [6:0] target_address
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rst_addr;
        $rose(rst_n) |-> target_address == 7'h7C;
    endproperty
    a_rst_addr: assert property (p_rst_addr) else $error("reset address");
    property p_rst_pin;
        $rose(rst_n) |=> target_address[1:0] == 2'h0;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin bits reset");
    property p_load;
        $rose(rst_n) |=> target_address[6:2] == $past(factory_target_address_bits);
    endproperty
    a_load: assert property (p_load) else $error("factory load");
    property p_mirror;
        $past(rst_n, 2) |->
            target_address[1:0] == $past({addr_select_pin_1, addr_select_pin_0}, 2);
    endproperty
    a_mirror: assert property (p_mirror) else $error("pin mirror");
    // Bus idle between a stop and the next start
    logic scl_prev_q;
    logic sda_prev_q;
    logic idle_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            idle_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
            if (scl_in && scl_prev_q && sda_prev_q && !sda_in) begin
                idle_q <= 1'b0;
            end else if (scl_in && scl_prev_q && !sda_prev_q && sda_in) begin
                idle_q <= 1'b1;
            end
        end
    end
    property p_idle_quiet;
        idle_q |-> sda_oe_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    property p_upper_wr;
        $past(rst_n, 2) && $changed(target_address[6:2]) |-> $fell(sda_oe_n);
    endproperty
    a_upper_wr: assert property (p_upper_wr) else $error("upper bits");
    property p_oe_scl;
        $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("drive edge");
    property p_oe_bound;
        $fell(sda_oe_n) |-> ##[1:400] sda_oe_n;
    endproperty
    a_oe_bound: assert property (p_oe_bound) else $error("drive hold");
endmodule : iiar_chk
bind iiar_regs iiar_chk iiar_chk_inst (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_pin_1(addr_select_pin_1), .addr_select_pin_0(addr_select_pin_0),
    .factory_variant_code(factory_variant_code),
    .factory_target_address_bits(factory_target_address_bits),
    .target_address(target_address));
`default_nettype wire

// File: verification/iiar_host.sv
/* Two-wire host model: start, stop, byte transfers.
   Assumes a pulled-up sda wire resolved by the bench. */
`timescale 1ns/1ps
`default_nettype none
module iiar_host (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam int H = 8;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic start();
        tick(2);
        sda_low <= 1'b0;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b0;
        tick(H);
    endtask : stop
    task automatic xbit(input logic b, output logic r);
        tick(2);
        sda_low <= !b;
        tick(H);
        scl <= 1'b1;
        tick(H);
        @(negedge clock);
        r = sda;
        @(posedge clock);
        scl <= 1'b0;
    endtask : xbit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, r);
    endtask : rbyte
endmodule : iiar_host
`default_nettype wire

// File: verification/test_ident_and_i2c_address_regs.sv
/* Bench for iiar_regs with a two-wire host model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module test_ident_and_i2c_address_regs;
    // Arbitrary identifier value
    localparam logic [15:0] PID = 16'hC3A5;
    localparam logic [10:0] VAR = 11'h2D6;
    logic clock, rst_n, pin1, pin0, host_low, scl, sda_out, sda_oe_n;
    wire logic sda;
    logic [6:0] target_address;
    logic [4:0] fact_addr;
    logic [7:0] got [6];
    logic [7:0] e [6] = '{{4'h0, PID[15:12]}, PID[11:4], {PID[3:0], VAR[10:7]},
        {VAR[6:0], 1'b1}, 8'h7C, 8'h00};
    int mismatches, tests_run;
    assign sda = !host_low && (sda_oe_n || sda_out);
    iiar_regs #(.PART_ID_DEFAULT(PID)) iiar_regs_inst (.clock(clock), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_pin_1(pin1), .addr_select_pin_0(pin0),
        .factory_variant_code(VAR), .factory_target_address_bits(fact_addr),
        .target_address(target_address));
    iiar_host iiar_host_inst (.clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic head(input logic [6:0] a, input logic [15:0] p, input logic ea);
        logic k;
        iiar_host_inst.start();
        iiar_host_inst.wbyte({a, 1'b0}, k);
        chk({7'h00, k}, {7'h00, ea});
        iiar_host_inst.wbyte(p[15:8], k);
        iiar_host_inst.wbyte(p[7:0], k);
    endtask : head
    task automatic wr(input logic [6:0] a, input logic [15:0] p, input logic [15:0] d);
        logic k;
        head(a, p, 1'b1);
        iiar_host_inst.wbyte(d[15:8], k);
        iiar_host_inst.wbyte(d[7:0], k);
        iiar_host_inst.stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [15:0] p, input int n);
        logic k;
        head(a, p, 1'b1);
        iiar_host_inst.start();
        iiar_host_inst.wbyte({a, 1'b1}, k);
        for (int i = 0; i < n; i++) iiar_host_inst.rbyte(i == n - 1, got[i]);
        iiar_host_inst.stop();
    endtask : rd
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        pin1 = 1'b0;
        pin0 = 1'b0;
        fact_addr = 5'h1F;
        repeat (5) @(posedge clock);
        chk({1'b0, target_address}, 8'h7C);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd(7'h7C, 16'h0002, 6);
        for (int i = 0; i < 6; i++) chk(got[i], e[i]);
        $display("Identification read done");
        pin1 <= 1'b1;
        repeat (4) @(posedge clock);
        chk({1'b0, target_address}, 8'h7E);
        wr(7'h7E, 16'h0006, 16'h8BFF);
        chk({1'b0, target_address}, 8'h0A);
        rd(7'h0A, 16'h0006, 2);
        chk(got[0], 8'h0A);
        chk(got[1], 8'h00);
        $display("Address write done");
        head(7'h7E, 16'h0006, 1'b0);
        iiar_host_inst.stop();
        $display("Old address refused");
        fact_addr <= 5'h0B;
        pin1 <= 1'b0;
        pin0 <= 1'b1;
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        chk({1'b0, target_address}, 8'h7C);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        chk({1'b0, target_address}, 8'h2D);
        rd(7'h2D, 16'h0006, 1);
        chk(got[0], 8'h2D);
        $display("Factory reload done");
        final_report();
    end
endmodule : test_ident_and_i2c_address_regs
`default_nettype wire
